// ===== bench/core_event_count_decode_test.sv
// Testbench for the event decoder, one task per scenario.
// Assumes the pipeline model drives every strobe and level.
`timescale 1ns/1ns
module core_event_count_decode_test;
  import event_decode_pkg::*;
  localparam int PEN = MISPREDICT_PENALTY;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] event_select = 8'h00;
  logic [7:0] unit_mask = 8'h00;
  logic [19:0] ev;
  logic count_inc, select_valid, disamb_flush;
  int fail_count = 0;
  int samples_checked = 0;

  core_pipe_model pipe (.ev(ev));

  core_event_count_decode #(.PENALTY_CYCLES(PEN)) dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n),
    .EVENT_SELECT(event_select), .UNIT_MASK(unit_mask),
    .LOAD_UNKNOWN_STORE_OK(ev[0]), .LOAD_COLLIDE_MISPREDICT(ev[1]),
    .WALK_START_DATA(ev[2]), .WALK_START_INSTR(ev[3]),
    .WALK_ACTIVE(ev[4]), .FLOAT_COMPUTE_UOP(ev[5]),
    .PRODUCT_OP(ev[6]), .QUOTIENT_OP(ev[7]),
    .LATE_FORWARD_FLOAT(ev[8]), .DENORMAL_INPUT_ZEROING_FLAG(ev[9]),
    .TINY_RESULT_FLUSH_FLAG(ev[10]), .VEC_DENORMAL_INPUT(ev[11]),
    .VEC_UNDERFLOW_RESULT(ev[12]), .STACK_NAN_DENORMAL_LOAD(ev[13]),
    .STACK_DIVIDE_BY_ZERO(ev[14]), .STACK_UNDERFLOW_OUTPUT(ev[15]),
    .DIV_BUSY(ev[16]), .UOP_DISPATCH(ev[17]),
    .EXEC_ACTIVE(ev[18]), .LOAD_DISPATCH(ev[19]),
    .COUNT_INC(count_inc), .SELECT_VALID(select_valid),
    .DISAMB_FLUSH(disamb_flush)
  );

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  // 125 MHz core clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Step to just after the next rising edge, where inputs change
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input string what, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %b seen %b", what, exp, seen);
      fail_count++;
    end
  endtask

  // Selection takes effect one edge after it is driven
  task automatic sel(input logic [7:0] c, input logic [7:0] m);
    event_select = c;
    unit_mask = m;
    tick();
  endtask

  // Drive a vector, let it settle, compare the increment
  task automatic step(input logic [19:0] v, input logic e, input string w);
    pipe.put(v);
    #2;
    check(w, count_inc, e);
    tick();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // single-source events
  task automatic simple_events();
    logic [7:0] c [9] = '{CODE_DISAMB, CODE_WALK, CODE_WALK, CODE_WALK,
      CODE_FP_UOP, CODE_PRODUCT, CODE_QUOTIENT, CODE_BYPASS, CODE_DIV_BUSY};
    logic [7:0] m [9] = '{MASK_SECOND, MASK_FIRST, MASK_FIRST, MASK_SECOND,
      MASK_NONE, MASK_NONE, MASK_NONE, MASK_NONE, MASK_NONE};
    int b [9] = '{0, 2, 3, 4, 5, 6, 7, 8, 16};
    // Sibling source that legitimately counts into the same event
    logic [19:0] sib [9] = '{20'h00000, 20'h00008, 20'h00004, 20'h00000,
      20'h00000, 20'h00000, 20'h00000, 20'h00000, 20'h00000};
    for (int i = 0; i < 9; i++) begin
      sel(c[i], m[i]);
      check("valid", select_valid, 1'b1);
      // Every unrelated source high must not leak into this counter
      step(~(20'h00001 << b[i]) & ~sib[i], 1'b0, "others");
      step(20'h00001 << b[i], 1'b1, "own");
      step(20'h00000, 1'b0, "quiet");
    end
  endtask

  // assist causes against the two mode flags
  task automatic assists();
    logic [19:0] v [7] = '{20'h00800, 20'h00A00, 20'h01000, 20'h01400,
      20'h02600, 20'h04600, 20'h08600};
    logic e [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    sel(CODE_FP_HELP, MASK_NONE);
    for (int i = 0; i < 7; i++) begin
      step(v[i], e[i], "assist");
    end
  endtask

  task automatic near_misses();
    logic [15:0] p [5] = '{16'h1101, 16'h0900, 16'h0C00, 16'h1001,
      16'h0000};
    for (int i = 0; i < 5; i++) begin
      sel(p[i][15:8], p[i][7:0]);
      check("invalid", select_valid, 1'b0);
      step(20'hFFFFF, 1'b0, "unlisted");
    end
    pipe.put(20'h00000);
    tick();
  endtask

  task automatic flush_run(input int n);
    for (int i = 0; i < n; i++) begin
      #2;
      check("flush", disamb_flush, 1'b1);
      check("flush inc", count_inc, 1'b1);
      tick();
    end
  endtask

  task automatic flush();
    // Let the window opened by earlier all-ones vectors run out first
    pipe.put(20'h00000);
    repeat (PEN) tick();
    sel(CODE_DISAMB, MASK_FIRST);
    check("flush idle", disamb_flush, 1'b0);
    step(20'h00002, 1'b0, "miss strobe");
    pipe.put(20'h00000);
    flush_run(10);
    pipe.put(20'h00002);
    flush_run(1);
    pipe.put(20'h00000);
    flush_run(PEN);
    #2;
    check("flush end", disamb_flush, 1'b0);
    check("flush end inc", count_inc, 1'b0);
    tick();
  endtask

  // Mid-run reset must close an open flush window and drop the selection
  task automatic mid_reset();
    sel(CODE_DISAMB, MASK_FIRST);
    step(20'h00002, 1'b0, "pre-reset strobe");
    pipe.put(20'h00000);
    reset_n = 1'b0;
    #2;
    check("reset flush", disamb_flush, 1'b0);
    check("reset valid", select_valid, 1'b0);
    check("reset inc", count_inc, 1'b0);
    tick();
    reset_n = 1'b1;
    tick();
    check("release valid", select_valid, 1'b1);
    check("release flush", disamb_flush, 1'b0);
  endtask

  // divider alone, then other units and a load
  task automatic div_idle();
    logic [19:0] v [9] = '{20'h50000, 20'h70000, 20'h50000, 20'h10000,
      20'h90000, 20'h10000, 20'h10000, 20'h10000, 20'h00000};
    logic e [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    sel(CODE_DIV_IDLE, MASK_NONE);
    for (int i = 0; i < 9; i++) begin
      step(v[i], e[i], "div idle");
    end
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The run needs well under a thousand cycles
  initial begin
    #40000;
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    tick();
    simple_events();
    assists();
    near_misses();
    flush();
    mid_reset();
    div_idle();
    end_sim();
  end
endmodule

// ===== bench/core_pipe_model.sv
// Core pipeline stand-in: drives occurrence strobes and activity levels.
// Assumes the bench calls put just after a rising edge of the core clock.
`timescale 1ns/1ns
module core_pipe_model (
  // Strobes and levels toward the decoder
  output logic [19:0] ev
);
  // ----------------------------------------------------------------
  // Drive
  // ----------------------------------------------------------------
  // Quiet pipeline until told otherwise
  initial ev = 20'h00000;

  // Whole vector at once, so one cycle's occurrences land together
  task automatic put(input logic [19:0] v);
    ev = v;
  endtask
endmodule

// ===== shared/event_decode_pkg.sv
// Event codes, unit masks and timing counts for the event decoder.
// Assumes both the decoder and its idle tracker import this package.
package event_decode_pkg;

  // ----------------------------------------------------------------
  // Event selection codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_DISAMB = 8'h09;
  localparam logic [7:0] CODE_WALK = 8'h0C;
  localparam logic [7:0] CODE_FP_UOP = 8'h10;
  localparam logic [7:0] CODE_FP_HELP = 8'h11;
  localparam logic [7:0] CODE_PRODUCT = 8'h12;
  localparam logic [7:0] CODE_QUOTIENT = 8'h13;
  localparam logic [7:0] CODE_DIV_BUSY = 8'h14;
  localparam logic [7:0] CODE_DIV_IDLE = 8'h18;
  localparam logic [7:0] CODE_BYPASS = 8'h19;

  // ----------------------------------------------------------------
  // Unit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_FIRST = 8'h01;
  localparam logic [7:0] MASK_SECOND = 8'h02;

  // ----------------------------------------------------------------
  // Timing counts in core cycles, and the widths of their counters
  // ----------------------------------------------------------------
  localparam int MISPREDICT_PENALTY = 20;
  localparam int PENALTY_W = 5;
  localparam int L1_HIT_LATENCY = 3;
  localparam int LOAD_W = 2;

  // ----------------------------------------------------------------
  // Decoded event kinds
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    EV_NONE,
    EV_DISAMB_RESET,
    EV_DISAMB_OK,
    EV_WALK_COUNT,
    EV_WALK_CYCLES,
    EV_FP_UOP,
    EV_FP_HELP,
    EV_PRODUCT,
    EV_QUOTIENT,
    EV_DIV_BUSY,
    EV_DIV_IDLE,
    EV_FP_BYPASS
  } event_kind_type;

  // Exact pair match; anything else selects nothing
  function automatic event_kind_type decode_pair(input logic [7:0] code,
                                                 input logic [7:0] mask);
    event_kind_type k;
    k = EV_NONE;
    case ({code, mask})
      {CODE_DISAMB, MASK_FIRST}: k = EV_DISAMB_RESET;
      {CODE_DISAMB, MASK_SECOND}: k = EV_DISAMB_OK;
      {CODE_WALK, MASK_FIRST}: k = EV_WALK_COUNT;
      {CODE_WALK, MASK_SECOND}: k = EV_WALK_CYCLES;
      {CODE_FP_UOP, MASK_NONE}: k = EV_FP_UOP;
      {CODE_FP_HELP, MASK_NONE}: k = EV_FP_HELP;
      {CODE_PRODUCT, MASK_NONE}: k = EV_PRODUCT;
      {CODE_QUOTIENT, MASK_NONE}: k = EV_QUOTIENT;
      {CODE_DIV_BUSY, MASK_NONE}: k = EV_DIV_BUSY;
      {CODE_DIV_IDLE, MASK_NONE}: k = EV_DIV_IDLE;
      {CODE_BYPASS, MASK_NONE}: k = EV_FP_BYPASS;
      default: k = EV_NONE;
    endcase
    return k;
  endfunction

endpackage

// ===== src/core_event_count_decode.sv
// Event selection and occurrence detection for one monitor counter.
// Assumes strobes come from pipeline logic on REF_CLK and that the
// counter adds one in every cycle that COUNT_INC is high.
`timescale 1ns/1ns
module core_event_count_decode
  import event_decode_pkg::*;
#(
  parameter int PENALTY_CYCLES = MISPREDICT_PENALTY,
  parameter int LOAD_LATENCY = L1_HIT_LATENCY
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Counter programming
  input wire logic [7:0] EVENT_SELECT,
  input wire logic [7:0] UNIT_MASK,
  // Memory ordering strobes
  input wire logic LOAD_UNKNOWN_STORE_OK,
  input wire logic LOAD_COLLIDE_MISPREDICT,
  // Translation walks
  input wire logic WALK_START_DATA,
  input wire logic WALK_START_INSTR,
  input wire logic WALK_ACTIVE,
  // Floating point and arithmetic strobes
  input wire logic FLOAT_COMPUTE_UOP,
  input wire logic PRODUCT_OP,
  input wire logic QUOTIENT_OP,
  input wire logic LATE_FORWARD_FLOAT,
  // Assist causes
  input wire logic DENORMAL_INPUT_ZEROING_FLAG,
  input wire logic TINY_RESULT_FLUSH_FLAG,
  input wire logic VEC_DENORMAL_INPUT,
  input wire logic VEC_UNDERFLOW_RESULT,
  input wire logic STACK_NAN_DENORMAL_LOAD,
  input wire logic STACK_DIVIDE_BY_ZERO,
  input wire logic STACK_UNDERFLOW_OUTPUT,
  // Divider and unit activity
  input wire logic DIV_BUSY,
  input wire logic UOP_DISPATCH,
  input wire logic EXEC_ACTIVE,
  input wire logic LOAD_DISPATCH,
  // Counter side
  output logic COUNT_INC,
  output logic SELECT_VALID,
  output logic DISAMB_FLUSH
);
  import event_decode_pkg::*;

  typedef struct packed {
    event_kind_type kind;
    logic [PENALTY_W-1:0] flush_cnt;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic div_idle;
  logic float_help;
  logic walk_start;

  // ----------------------------------------------------------------
  // Divider idle tracking
  // ----------------------------------------------------------------
  div_idle_track #(
    .LOAD_LATENCY(LOAD_LATENCY)
  ) u_idle (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .div_busy(DIV_BUSY),
    .uop_dispatch(UOP_DISPATCH),
    .exec_active(EXEC_ACTIVE),
    .load_dispatch(LOAD_DISPATCH),
    .div_idle(div_idle)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Selection is registered so the wide compare stays off the strobe path
  always_comb begin
    s_d = s_q;
    s_d.kind = decode_pair(EVENT_SELECT, UNIT_MASK);
    if (LOAD_COLLIDE_MISPREDICT) begin
      s_d.flush_cnt = PENALTY_W'(PENALTY_CYCLES);
    end else if (s_q.flush_cnt != '0) begin
      s_d.flush_cnt = s_q.flush_cnt - 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '{kind: EV_NONE, flush_cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Occurrence terms
  // ----------------------------------------------------------------
  // vector and stack assist causes
  assign float_help =
    (VEC_DENORMAL_INPUT && !DENORMAL_INPUT_ZEROING_FLAG) ||
    (VEC_UNDERFLOW_RESULT && !TINY_RESULT_FLUSH_FLAG) ||
    STACK_NAN_DENORMAL_LOAD || STACK_DIVIDE_BY_ZERO ||
    STACK_UNDERFLOW_OUTPUT;
  assign walk_start = WALK_START_DATA || WALK_START_INSTR;
  assign DISAMB_FLUSH = (s_q.flush_cnt != '0);
  assign SELECT_VALID = (s_q.kind != EV_NONE);

  // Strobes pass straight through so the count lands in their own cycle, except the mispredict strobe, counted in the cycles after it
  // same-cycle increment
  always_comb begin
    case (s_q.kind)
      EV_DISAMB_RESET: COUNT_INC = DISAMB_FLUSH;
      EV_DISAMB_OK: COUNT_INC = LOAD_UNKNOWN_STORE_OK;
      EV_WALK_COUNT: COUNT_INC = walk_start;
      EV_WALK_CYCLES: COUNT_INC = WALK_ACTIVE;
      EV_FP_UOP: COUNT_INC = FLOAT_COMPUTE_UOP;
      EV_FP_HELP: COUNT_INC = float_help;
      EV_PRODUCT: COUNT_INC = PRODUCT_OP;
      EV_QUOTIENT: COUNT_INC = QUOTIENT_OP;
      EV_DIV_BUSY: COUNT_INC = DIV_BUSY;
      EV_DIV_IDLE: COUNT_INC = div_idle;
      EV_FP_BYPASS: COUNT_INC = LATE_FORWARD_FLOAT;
      default: COUNT_INC = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_WALK_SELECT: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (EVENT_SELECT == CODE_WALK && UNIT_MASK == MASK_SECOND)
    |=> (s_q.kind == EV_WALK_CYCLES && (COUNT_INC == WALK_ACTIVE)))
    else $error("walk cycle selection not applied");

  AST_NO_MATCH_QUIET: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    !SELECT_VALID |-> !COUNT_INC)
    else $error("increment without a valid selection");

  AST_FLUSH_LENGTH: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    LOAD_COLLIDE_MISPREDICT |=> (s_q.flush_cnt == 5'h14) ##19 DISAMB_FLUSH)
    else $error("flush window shorter than the penalty");

  AST_FLUSH_ENDS: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (s_q.flush_cnt == 5'h01 && !LOAD_COLLIDE_MISPREDICT) |=> !DISAMB_FLUSH)
    else $error("flush window longer than the penalty");

  AST_FLUSH_COUNTS: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (s_q.kind == EV_DISAMB_RESET && $past(LOAD_COLLIDE_MISPREDICT))
    |-> COUNT_INC)
    else $error("flush cycle not counted");

  AST_VEC_ZEROING_MASKS: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (s_q.kind == EV_FP_HELP && VEC_DENORMAL_INPUT &&
     DENORMAL_INPUT_ZEROING_FLAG && !VEC_UNDERFLOW_RESULT &&
     !STACK_NAN_DENORMAL_LOAD && !STACK_DIVIDE_BY_ZERO &&
     !STACK_UNDERFLOW_OUTPUT) |-> !COUNT_INC)
    else $error("assist counted while zeroing flag set");

  AST_STACK_ASSIST: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (s_q.kind == EV_FP_HELP && STACK_DIVIDE_BY_ZERO) |-> COUNT_INC)
    else $error("stack assist missed");

  AST_WALK_START: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (s_q.kind == EV_WALK_COUNT && WALK_START_INSTR) |-> COUNT_INC)
    else $error("instruction walk start missed");

  AST_PRODUCT: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (s_q.kind == EV_PRODUCT) |-> (COUNT_INC == PRODUCT_OP))
    else $error("multiply count mismatch");

  AST_IDLE_NOT_BUSY: assert property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    (s_q.kind == EV_DIV_IDLE && (!DIV_BUSY || LOAD_DISPATCH))
    |-> !COUNT_INC)
    else $error("idle counted while divider free or load active");

  COV_FLUSH: cover property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    s_q.kind == EV_DISAMB_RESET && LOAD_COLLIDE_MISPREDICT ##1 COUNT_INC);

  COV_IDLE: cover property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    s_q.kind == EV_DIV_IDLE && COUNT_INC);

  COV_ASSIST: cover property (
    @(posedge REF_CLK) disable iff (!RESET_N)
    s_q.kind == EV_FP_HELP && VEC_UNDERFLOW_RESULT && COUNT_INC);

endmodule

// ===== src/div_idle_track.sv
// Divider idle tracker: flags cycles where only the divider works.
// Assumes all strobes come from core logic on the same clock.
`timescale 1ns/1ns
module div_idle_track
  import event_decode_pkg::*;
#(
  parameter int LOAD_LATENCY = L1_HIT_LATENCY
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core activity
  input wire logic div_busy,
  input wire logic uop_dispatch,
  input wire logic exec_active,
  input wire logic load_dispatch,
  // Result
  output logic div_idle
);
  import event_decode_pkg::*;

  typedef struct packed {
    logic busy_prev;
    logic seen_after;
    logic [LOAD_W-1:0] load_cnt;
  } track_type;

  track_type s_q;
  track_type s_d;
  logic load_now;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Work dispatched before the divider started is ignored on purpose
  always_comb begin
    s_d = s_q;
    s_d.busy_prev = div_busy;
    if (div_busy && !s_q.busy_prev) begin
      s_d.seen_after = uop_dispatch;
    end else if (div_busy && uop_dispatch) begin
      s_d.seen_after = 1'b1;
    end else if (!div_busy) begin
      s_d.seen_after = 1'b0;
    end
    if (div_busy && load_dispatch) begin
      s_d.load_cnt = LOAD_W'(LOAD_LATENCY - 1);
    end else if (s_q.load_cnt != '0) begin
      s_d.load_cnt = s_q.load_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign load_now = (div_busy && load_dispatch) || (s_q.load_cnt != '0);
  assign div_idle = div_busy && !load_now &&
                    !(exec_active && (s_d.seen_after || s_q.seen_after));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LOAD_BLOCKS: assert property (
    @(posedge clk) disable iff (!rst_n)
    (div_busy && load_dispatch) |-> !div_idle ##1 (!div_busy || !div_idle))
    else $error("idle flagged during an assumed load hit");

  AST_IDLE_NEEDS_BUSY: assert property (
    @(posedge clk) disable iff (!rst_n)
    div_idle |-> div_busy)
    else $error("idle flagged without divider busy");

endmodule
